// *** hdl/can_rx_pkg.sv ***
package can_rx_pkg;
  localparam logic [7:0]  RX_FIFO0_STATUS_OFS = 8'h0C;
  localparam logic [7:0]  RX_FIFO1_STATUS_OFS = 8'h10;
  localparam logic [7:0]  IRQ_EN_OFS          = 8'h14;
  localparam int          ADR_MSB             = 7;
  localparam int          ADR_LSB             = 2;
  localparam int          COUNT_LSB           = 0;
  localparam int          COUNT_MSB           = 1;
  localparam int          RSVD_BIT            = 2;
  localparam int          FULL_BIT            = 3;
  localparam int          OVR_BIT             = 4;
  localparam int          REL_BIT             = 5;
  localparam int          RSVD_HI_LSB         = 6;
  localparam int          PEND0_IEN_BIT       = 1;
  localparam int          FULL0_IEN_BIT       = 2;
  localparam int          OVR0_IEN_BIT        = 3;
  localparam int          PEND1_IEN_BIT       = 4;
  localparam int          FULL1_IEN_BIT       = 5;
  localparam int          OVR1_IEN_BIT        = 6;
  localparam logic [1:0]  CNT_ZERO            = 2'h0;
  localparam logic [1:0]  CNT_ONE             = 2'h1;
  localparam logic [1:0]  LAST_IDX            = 2'h2;
  localparam logic [1:0]  MSG_DEPTH           = 2'h3;
  localparam logic [5:0]  IRQ_EN_RESET        = 6'h00;
  localparam logic [31:0] REG_RESET           = 32'h0000_0000;
endpackage : can_rx_pkg

// *** hdl/rx_fifo_if.sv ***
`timescale 1ns/1ns
interface rx_fifo_if;
  logic       store;
  logic       clr_full;
  logic       clr_ovr;
  logic       rel_wr;
  logic [1:0] count;
  logic [1:0] head;
  logic [1:0] tail;
  logic       full;
  logic       ovr;
  logic       rel;
  logic       pop;
  logic       accept;
  modport ctrl (input store, clr_full, clr_ovr, rel_wr,
                output count, head, tail, full, ovr, rel, pop, accept);
  modport host (output store, clr_full, clr_ovr, rel_wr,
                input count, head, tail, full, ovr, rel, pop, accept);
endinterface : rx_fifo_if

// *** hdl/rx_fifo_ctrl.sv ***
`timescale 1ns/1ns
module rx_fifo_ctrl (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  rx_fifo_if.ctrl   f
);
  logic at_full;

  function automatic logic [1:0] next_idx(input logic [1:0] i);
    next_idx = (i == can_rx_pkg::LAST_IDX) ? can_rx_pkg::CNT_ZERO : 2'(i + can_rx_pkg::CNT_ONE);
  endfunction : next_idx

  assign at_full  = (f.count == can_rx_pkg::MSG_DEPTH);
  assign f.pop    = f.rel & ce_i;
  assign f.accept = f.store & ce_i & (~at_full | f.pop);

  // Message count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      f.count <= can_rx_pkg::CNT_ZERO;
    else if (f.accept & ~f.pop)
      f.count <= 2'(f.count + can_rx_pkg::CNT_ONE);
    else if (f.pop & ~f.accept)
      f.count <= 2'(f.count - can_rx_pkg::CNT_ONE);
  end

  // Oldest and next slot indices
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      f.head <= can_rx_pkg::CNT_ZERO;
      f.tail <= can_rx_pkg::CNT_ZERO;
    end
    else
    begin
      if (f.pop)
        f.head <= next_idx(f.head);
      if (f.accept)
        f.tail <= next_idx(f.tail);
    end
  end

  // Full flag, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      f.full <= 1'b0;
    else if (ce_i)
    begin
      if (f.accept & ~f.pop & (f.count == can_rx_pkg::LAST_IDX))
        f.full <= 1'b1;
      else if (f.clr_full)
        f.full <= 1'b0;
    end
  end

  // Overrun flag, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      f.ovr <= 1'b0;
    else if (ce_i)
    begin
      if (f.store & at_full & ~f.pop)
        f.ovr <= 1'b1;
      else if (f.clr_ovr)
        f.ovr <= 1'b0;
    end
  end

  // Release request, self clearing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      f.rel <= 1'b0;
    else if (ce_i)
    begin
      if (f.rel)
        f.rel <= 1'b0;
      else if (f.rel_wr & (f.count != can_rx_pkg::CNT_ZERO))
        f.rel <= 1'b1;
    end
  end

  property p_count_inc;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && f.store && !at_full && !f.pop) |=> (f.count == 2'($past(f.count) + 2'h1));
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not rise on store");

  property p_count_dec;
    @(posedge clk_i) disable iff (rst_i)
    (f.pop && !f.store) |=> (f.count == 2'($past(f.count) - 2'h1));
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count did not fall on release");

  property p_full_set;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && f.store && f.count == 2'h2 && !f.pop) |=> (f.full && f.count == 2'h3);
  endproperty
  a_full_set: assert property (p_full_set) else $error("full not set at three");

  property p_full_hold;
    @(posedge clk_i) disable iff (rst_i)
    (f.full && !(ce_i && f.clr_full)) |=> f.full;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full dropped without clear");

  property p_ovr_set;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && f.store && f.count == 2'h3 && !f.pop) |=> (f.ovr && f.count == 2'h3 && $stable(f.tail));
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun handling wrong");

  property p_ovr_hold;
    @(posedge clk_i) disable iff (rst_i)
    (f.ovr && !(ce_i && f.clr_ovr)) |=> f.ovr;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped without clear");

  property p_rel_clear;
    @(posedge clk_i) disable iff (rst_i)
    (f.rel && ce_i) |=> (!f.rel && f.head != $past(f.head));
  endproperty
  a_rel_clear: assert property (p_rel_clear) else $error("release not consumed");

  property p_rel_ignore;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && f.rel_wr && f.count == 2'h0 && !f.rel) |=> !f.rel;
  endproperty
  a_rel_ignore: assert property (p_rel_ignore) else $error("release taken while empty");
endmodule : rx_fifo_ctrl

// *** hdl/can_rx_fifo_status.sv ***
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
module can_rx_fifo_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx0_store_i,
  input  wire logic        rx1_store_i,
  output logic             rx0_accept_o,
  output logic             rx1_accept_o,
  output logic      [1:0]  rx0_head_o,
  output logic      [1:0]  rx1_head_o,
  output logic      [1:0]  rx0_tail_o,
  output logic      [1:0]  rx1_tail_o,
  output logic             rx0_pop_o,
  output logic             rx1_pop_o,
  output logic             irq_o
);
  rx_fifo_if f0 ();
  rx_fifo_if f1 ();

  logic       req;
  logic       wr_fire;
  logic       sel_f0;
  logic       sel_f1;
  logic       sel_ien;
  logic [6:1] irq_en;
  logic [6:1] irq_src;
  logic [31:0] next_rd;
  logic [31:0] f0_word;
  logic [31:0] f1_word;

  assign req     = wb_cyc_i & wb_stb_i;
  assign sel_f0  = (wb_adr_i == can_rx_pkg::RX_FIFO0_STATUS_OFS[can_rx_pkg::ADR_MSB:can_rx_pkg::ADR_LSB]);
  assign sel_f1  = (wb_adr_i == can_rx_pkg::RX_FIFO1_STATUS_OFS[can_rx_pkg::ADR_MSB:can_rx_pkg::ADR_LSB]);
  assign sel_ien = (wb_adr_i == can_rx_pkg::IRQ_EN_OFS[can_rx_pkg::ADR_MSB:can_rx_pkg::ADR_LSB]);
  // Write takes effect at the edge where ack is high, low byte lane only
  assign wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0] & ce_i;

  assign f0.store    = rx0_store_i;
  assign f1.store    = rx1_store_i;
  assign f0.clr_full = wr_fire & sel_f0 & wb_dat_i[can_rx_pkg::FULL_BIT];
  assign f1.clr_full = wr_fire & sel_f1 & wb_dat_i[can_rx_pkg::FULL_BIT];
  assign f0.clr_ovr  = wr_fire & sel_f0 & wb_dat_i[can_rx_pkg::OVR_BIT];
  assign f1.clr_ovr  = wr_fire & sel_f1 & wb_dat_i[can_rx_pkg::OVR_BIT];
  assign f0.rel_wr   = wr_fire & sel_f0 & wb_dat_i[can_rx_pkg::REL_BIT];
  assign f1.rel_wr   = wr_fire & sel_f1 & wb_dat_i[can_rx_pkg::REL_BIT];

  rx_fifo_ctrl u_fifo0 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .f     (f0.ctrl)
  );

  rx_fifo_ctrl u_fifo1 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .f     (f1.ctrl)
  );

  assign rx0_accept_o = f0.accept;
  assign rx1_accept_o = f1.accept;
  assign rx0_head_o   = f0.head;
  assign rx1_head_o   = f1.head;
  assign rx0_tail_o   = f0.tail;
  assign rx1_tail_o   = f1.tail;
  assign rx0_pop_o    = f0.pop;
  assign rx1_pop_o    = f1.pop;

  // Status words, reserved bits zero
  always_comb
  begin
    f0_word = can_rx_pkg::REG_RESET;
    f0_word[can_rx_pkg::COUNT_MSB:can_rx_pkg::COUNT_LSB] = f0.count;
    f0_word[can_rx_pkg::FULL_BIT] = f0.full;
    f0_word[can_rx_pkg::OVR_BIT]  = f0.ovr;
    f0_word[can_rx_pkg::REL_BIT]  = f0.rel;
    f1_word = can_rx_pkg::REG_RESET;
    f1_word[can_rx_pkg::COUNT_MSB:can_rx_pkg::COUNT_LSB] = f1.count;
    f1_word[can_rx_pkg::FULL_BIT] = f1.full;
    f1_word[can_rx_pkg::OVR_BIT]  = f1.ovr;
    f1_word[can_rx_pkg::REL_BIT]  = f1.rel;
  end

  // Read mux, unmapped reads zero
  always_comb
  begin
    next_rd = can_rx_pkg::REG_RESET;
    if (sel_f0)
      next_rd = f0_word;
    else if (sel_f1)
      next_rd = f1_word;
    else if (sel_ien)
      next_rd[can_rx_pkg::OVR1_IEN_BIT:can_rx_pkg::PEND0_IEN_BIT] = irq_en;
  end

  // Bus acknowledge, one cycle per request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= req & ~wb_ack_o;
  end

  // Read data capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= can_rx_pkg::REG_RESET;
    else if (ce_i & req & ~wb_ack_o)
      wb_dat_o <= next_rd;
  end

  // Interrupt enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_en <= can_rx_pkg::IRQ_EN_RESET;
    else if (wr_fire & sel_ien)
      irq_en <= wb_dat_i[can_rx_pkg::OVR1_IEN_BIT:can_rx_pkg::PEND0_IEN_BIT];
  end

  // Interrupt sources in enable layout
  always_comb
  begin
    irq_src = can_rx_pkg::IRQ_EN_RESET;
    irq_src[can_rx_pkg::PEND0_IEN_BIT] = (f0.count != can_rx_pkg::CNT_ZERO);
    irq_src[can_rx_pkg::FULL0_IEN_BIT] = f0.full;
    irq_src[can_rx_pkg::OVR0_IEN_BIT]  = f0.ovr;
    irq_src[can_rx_pkg::PEND1_IEN_BIT] = (f1.count != can_rx_pkg::CNT_ZERO);
    irq_src[can_rx_pkg::FULL1_IEN_BIT] = f1.full;
    irq_src[can_rx_pkg::OVR1_IEN_BIT]  = f1.ovr;
  end

  assign irq_o = |(irq_en & irq_src);

  property p_irq_pend;
    @(posedge clk_i) disable iff (rst_i)
    (irq_en[1] && f0.count != 2'h0) || (irq_en[4] && f1.count != 2'h0) |-> irq_o;
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("pending interrupt missing");

  property p_irq_flags;
    @(posedge clk_i) disable iff (rst_i)
    (irq_o == ((irq_en[1] && f0.count != 2'h0) || (irq_en[2] && f0.full) ||
               (irq_en[3] && f0.ovr) || (irq_en[4] && f1.count != 2'h0) ||
               (irq_en[5] && f1.full) || (irq_en[6] && f1.ovr)));
  endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("interrupt level wrong");

  property p_reset_zero;
    @(posedge clk_i)
    rst_i |=> (f0_word == 32'h0000_0000 && f1_word == 32'h0000_0000 && !irq_o);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && (sel_f0 || sel_f1)) |->
      (wb_dat_o[31:6] == 26'h0000000 && !wb_dat_o[2]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
endmodule : can_rx_fifo_status

// *** dv/rx_path_model.sv ***
`timescale 1ns/1ns
module rx_path_model (
  input  wire logic       clk_i,
  input  wire logic       accept_i,
  input  wire logic [1:0] tail_i,
  input  wire logic [1:0] head_i,
  output logic      [7:0] msg_o
);
  logic [7:0] mem [0:2];
  logic [7:0] next_id = 8'h01;
  // Message body written at tail slot on accept
  always @(posedge clk_i)
  begin
    if (accept_i)
    begin
      mem[tail_i] <= next_id;
      next_id     <= next_id + 8'h01;
    end
  end
  // Output mailbox shows the oldest slot
  assign msg_o = (head_i <= 2'h2) ? mem[head_i] : 8'hA5;
endmodule : rx_path_model

// *** dv/can_rx_fifo_status_tb.sv ***
`timescale 1ns/1ns
module can_rx_fifo_status_tb;
  localparam logic [7:0] F0 = can_rx_pkg::RX_FIFO0_STATUS_OFS;
  localparam logic [7:0] F1 = can_rx_pkg::RX_FIFO1_STATUS_OFS;
  localparam logic [7:0] IE = can_rx_pkg::IRQ_EN_OFS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:2]  adr   = 6'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0000_0000;
  logic [1:0]  store = 2'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [1:0]  accept;
  logic [1:0]  head0, head1, tail0, tail1;
  logic [7:0]  msg0, msg1;
  logic [1:0]  pop;
  logic        ce    = 1'b1;
  logic [31:0] expq [$];
  int          failures = 0;
  int          checked  = 0;
  int          n;
  int          acc1     = 0;
  int          nrel     = 1;
  int          npop     = 0;
  always #2 clk_i = ~clk_i;
  can_rx_fifo_status DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx0_store_i(store[0]), .rx1_store_i(store[1]),
    .rx0_accept_o(accept[0]), .rx1_accept_o(accept[1]), .rx0_head_o(head0),
    .rx1_head_o(head1), .rx0_tail_o(tail0), .rx1_tail_o(tail1), .rx0_pop_o(pop[0]),
    .rx1_pop_o(pop[1]), .irq_o(irq));
  rx_path_model rx0 (.clk_i(clk_i), .accept_i(accept[0]), .tail_i(tail0),
    .head_i(head0), .msg_o(msg0));
  rx_path_model rx1 (.clk_i(clk_i), .accept_i(accept[1]), .tail_i(tail1),
    .head_i(head1), .msg_o(msg1));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Classic single cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a[7:2];
    sel <= 4'hF;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 40);
    if (k >= 40)
      failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Receive path: store held high for cnt back-to-back cycles
  task automatic burst(input int f, input int cnt);
    if (cnt > 0)
    begin
      @(posedge clk_i);
      store[f] <= 1'b1;
      repeat (cnt) @(posedge clk_i);
      store[f] <= 1'b0;
    end
  endtask : burst
  function automatic logic [31:0] stat(input int k);
    stat = {27'h0, k >= 4, k >= 3, 1'b0, (k >= 3) ? 2'h3 : 2'(k)};
  endfunction : stat
  // Read data compared against oldest note
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      check(rdat, expq.pop_front());
  end
  // Pop pulses seen on both FIFOs
  always @(posedge clk_i)
  begin
    npop += int'(pop[0] === 1'b1) + int'(pop[1] === 1'b1);
  end
  initial
  begin
    n = $urandom(32'hEC41);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(F0, 32'h0000_0000);
    rd(F1, 32'h0000_0000);
    rd(IE, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    bus(1'b1, F0, 32'h0000_0020);
    rd(F0, 32'h0000_0000);
    burst(0, 4);
    rd(F0, stat(4));
    #1 check({24'h0, msg0}, 32'h0000_0001);
    bus(1'b1, F0, 32'h0000_0000);
    rd(F0, stat(4));
    bus(1'b1, F0, 32'hFFFF_FFDC);
    rd(F0, 32'h0000_0003);
    bus(1'b1, F0, 32'h0000_0020);
    rd(F0, 32'h0000_0002);
    #1 check({24'h0, msg0}, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, IE, 32'h0000_0002);
    #1 check({31'h0, irq}, 32'h0000_0001);
    @(posedge clk_i);
    ce       <= 1'b0;
    store[0] <= 1'b1;
    @(posedge clk_i);
    ce       <= 1'b1;
    store[0] <= 1'b0;
    rd(F0, 32'h0000_0002);
    repeat (4)
    begin
      n = $urandom_range(4, 0);
      burst(1, n);
      rd(F1, stat(n));
      if (n > 0)
        #1 check({24'h0, msg1}, acc1 + 1);
      acc1 += (n > 3) ? 3 : n;
      nrel += (n > 3) ? 3 : n;
      for (int b = 0; b < 3; b++)
      begin
        bus(1'b1, IE, 32'h0000_0010 << b);
        #1 check({31'h0, irq}, {31'h0, n >= ((b == 0) ? 1 : b + 2)});
      end
      bus(1'b1, F1, 32'h0000_0018);
      repeat ((n > 3) ? 3 : n) bus(1'b1, F1, 32'h0000_0020);
      rd(F1, 32'h0000_0000);
    end
    check(npop, nrel);
    test_done();
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    failures++;
    test_done();
  end
endmodule : can_rx_fifo_status_tb
